// ### rtl/sog_guard.sv
`timescale 1ns/1ps
module sog_guard
    import sog_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic      [1:0]        s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic      [DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    input  wire logic              enableCmd,
    input  wire logic [DEV_W-1:0]  posRef,
    input  wire logic              posRefValid,
    input  wire logic [DEV_W-1:0]  actualPos,
    output logic                   servoOn,
    output logic                   speedLimitActive,
    output logic      [SPD_W-1:0]  speedLimit,
    output logic                   enableTimeWarning,
    output logic      [ST_W-1:0]   alarms,
    output logic                   irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DEV_W-1:0]  devVal;
    logic [DEV_W-1:0]  devMag;
    logic [LVL_W-1:0]  warnLvl;

    logic              awHave_ff,  nxt_awHave;
    logic              wHave_ff,   nxt_wHave;
    logic [ADDR_W-1:0] awAddr_ff,  nxt_awAddr;
    logic [DATA_W-1:0] wData_ff,   nxt_wData;
    logic [3:0]        wStrb_ff,   nxt_wStrb;
    logic              bValid_ff,  nxt_bValid;
    logic [1:0]        bResp_ff,   nxt_bResp;
    logic              rValid_ff,  nxt_rValid;
    logic [DATA_W-1:0] rData_ff,   nxt_rData;
    logic [1:0]        rResp_ff,   nxt_rResp;
    logic              doWrite;

    logic              linSel_ff,  nxt_linSel;
    logic              arst_ff,    nxt_arst;
    logic [LVL_W-1:0]  alvl_ff,    nxt_alvl;
    logic [PCT_W-1:0]  wpct_ff,    nxt_wpct;
    logic [SPD_W-1:0]  rspd_ff,    nxt_rspd;
    logic [SPD_W-1:0]  lspd_ff,    nxt_lspd;
    logic [LVL_W-1:0]  glvl_ff,    nxt_glvl;
    logic [ST_W-1:0]   status_ff,  nxt_status;
    logic [ST_W-1:0]   mask_ff,    nxt_mask;
    logic [ST_W-1:0]   stClr;
    logic [DATA_W-1:0] wv;

    sog_state_t        state_ff,   nxt_state;
    logic              enaPrev_ff;
    logic              lim_ff,     nxt_lim;
    logic              refSeen_ff, nxt_refSeen;
    logic              warn_ff,    nxt_warn;
    logic [ST_W-1:0]   alarm_ff,   nxt_alarm;
    logic [ST_W-1:0]   evt;
    logic              overAlvl;
    logic              overGen;
    logic              overWarn;
    logic              enaRise;
    logic              irq_ff;
    logic [SPD_W-1:0]  spd_ff;

    function automatic logic [DATA_W-1:0] mergeStrb(
        input logic [DATA_W-1:0] oldv,
        input logic [DATA_W-1:0] newv,
        input logic [3:0]        strb
    );
        logic [DATA_W-1:0] r;
        r = oldv;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = newv[i*8 +: 8];
        end
        mergeStrb = r;
    endfunction

    function automatic logic lvlOk(input logic [DATA_W-1:0] v);
        lvlOk = (v[LVL_W-1:0] >= LVL_MIN) && (v[DATA_W-1:LVL_W] == 2'h0);
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    sog_dev_counter u_dev (
        .clk       (clk),
        .rstn      (rstn),
        .posRef    (posRef),
        .actualPos (actualPos),
        .devVal_ff (devVal),
        .devMag_ff (devMag)
    );

    sog_warn_level u_warn (
        .clk        (clk),
        .rstn       (rstn),
        .level      (alvl_ff),
        .pct        (wpct_ff),
        .warnLvl_ff (warnLvl)
    );

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign doWrite = awHave_ff && wHave_ff && !bValid_ff;

    always_comb
    begin
        nxt_awHave = awHave_ff;
        nxt_wHave  = wHave_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wData  = wData_ff;
        nxt_wStrb  = wStrb_ff;
        nxt_bValid = bValid_ff;
        nxt_bResp  = bResp_ff;
        nxt_rValid = rValid_ff;
        nxt_rData  = rData_ff;
        nxt_rResp  = rResp_ff;
        if (s_axi_awvalid && !awHave_ff)
        begin
            nxt_awHave = 1'b1;
            nxt_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHave_ff)
        begin
            nxt_wHave = 1'b1;
            nxt_wData = s_axi_wdata;
            nxt_wStrb = s_axi_wstrb;
        end
        if (doWrite)
        begin
            nxt_awHave = 1'b0;
            nxt_wHave  = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bResp  = RESP_OK;
            if (awAddr_ff > OFF_MASK || awAddr_ff[1:0] != 2'h0)
                nxt_bResp = RESP_ERR;
        end
        else if (bValid_ff && s_axi_bready)
            nxt_bValid = 1'b0;
        if (s_axi_arvalid && !rValid_ff)
        begin
            nxt_rValid = 1'b1;
            nxt_rResp  = RESP_OK;
            nxt_rData  = 32'h00000000;
            unique case (s_axi_araddr)
                OFF_CTRL:   nxt_rData[CTRL_LIN] = linSel_ff;
                OFF_ALVL:   nxt_rData[LVL_W-1:0] = alvl_ff;
                OFF_WPCT:   nxt_rData[PCT_W-1:0] = wpct_ff;
                OFF_RSPD:   nxt_rData[SPD_W-1:0] = rspd_ff;
                OFF_LSPD:   nxt_rData[SPD_W-1:0] = lspd_ff;
                OFF_GLVL:   nxt_rData[LVL_W-1:0] = glvl_ff;
                OFF_STATUS: nxt_rData[ST_W-1:0] = status_ff;
                OFF_MASK:   nxt_rData[ST_W-1:0] = mask_ff;
                OFF_STATE:
                begin
                    nxt_rData[SS_ON]   = state_ff == SOG_ON;
                    nxt_rData[SS_LIM]  = lim_ff;
                    nxt_rData[SS_WARN] = warn_ff;
                    nxt_rData[SS_ALM +: ST_W] = alarm_ff;
                end
                OFF_DEV:    nxt_rData = devVal;
                default:    nxt_rResp = RESP_ERR;
            endcase
        end
        else if (rValid_ff && s_axi_rready)
            nxt_rValid = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            awHave_ff <= 1'b0;
            wHave_ff  <= 1'b0;
            awAddr_ff <= 6'h00;
            wData_ff  <= 32'h00000000;
            wStrb_ff  <= 4'h0;
            bValid_ff <= 1'b0;
            bResp_ff  <= RESP_OK;
            rValid_ff <= 1'b0;
            rData_ff  <= 32'h00000000;
            rResp_ff  <= RESP_OK;
        end
        else
        begin
            awHave_ff <= nxt_awHave;
            wHave_ff  <= nxt_wHave;
            awAddr_ff <= nxt_awAddr;
            wData_ff  <= nxt_wData;
            wStrb_ff  <= nxt_wStrb;
            bValid_ff <= nxt_bValid;
            bResp_ff  <= nxt_bResp;
            rValid_ff <= nxt_rValid;
            rData_ff  <= nxt_rData;
            rResp_ff  <= nxt_rResp;
        end
    end

    // ------------------------------------------------------------
    // settings and interrupt registers
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_linSel = linSel_ff;
        nxt_arst   = 1'b0;
        nxt_alvl   = alvl_ff;
        nxt_wpct   = wpct_ff;
        nxt_rspd   = rspd_ff;
        nxt_lspd   = lspd_ff;
        nxt_glvl   = glvl_ff;
        nxt_mask   = mask_ff;
        stClr      = 4'h0;
        wv         = 32'h00000000;
        if (doWrite)
        begin
            unique case (awAddr_ff)
                OFF_CTRL:
                begin
                    wv = mergeStrb({30'h0, linSel_ff, 1'b0},
                                   wData_ff, wStrb_ff);
                    nxt_linSel = wv[CTRL_LIN];
                    nxt_arst   = wv[CTRL_ARST];
                end
                OFF_ALVL:
                begin
                    wv = mergeStrb({2'h0, alvl_ff}, wData_ff, wStrb_ff);
                    if (lvlOk(wv))
                        nxt_alvl = wv[LVL_W-1:0];
                end
                OFF_WPCT:
                begin
                    wv = mergeStrb({25'h0, wpct_ff}, wData_ff, wStrb_ff);
                    if (wv[DATA_W-1:PCT_W] == 25'h0
                        && wv[PCT_W-1:0] >= PCT_MIN
                        && wv[PCT_W-1:0] <= PCT_MAX)
                        nxt_wpct = wv[PCT_W-1:0];
                end
                OFF_RSPD:
                begin
                    wv = mergeStrb({18'h0, rspd_ff}, wData_ff, wStrb_ff);
                    if (wv[DATA_W-1:SPD_W] == 18'h0
                        && wv[SPD_W-1:0] <= SPD_MAX)
                        nxt_rspd = wv[SPD_W-1:0];
                end
                OFF_LSPD:
                begin
                    wv = mergeStrb({18'h0, lspd_ff}, wData_ff, wStrb_ff);
                    if (wv[DATA_W-1:SPD_W] == 18'h0
                        && wv[SPD_W-1:0] <= SPD_MAX)
                        nxt_lspd = wv[SPD_W-1:0];
                end
                OFF_GLVL:
                begin
                    wv = mergeStrb({2'h0, glvl_ff}, wData_ff, wStrb_ff);
                    if (lvlOk(wv))
                        nxt_glvl = wv[LVL_W-1:0];
                end
                OFF_STATUS:
                    stClr = wData_ff[ST_W-1:0] & {ST_W{wStrb_ff[0]}};
                OFF_MASK:
                begin
                    wv = mergeStrb({28'h0, mask_ff}, wData_ff, wStrb_ff);
                    nxt_mask = wv[ST_W-1:0];
                end
                default:
                    wv = 32'h00000000;
            endcase
        end
        // set wins over a write-one clear
        nxt_status = (status_ff & ~stClr) | evt;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            linSel_ff <= 1'b0;
            arst_ff   <= 1'b0;
            alvl_ff   <= LVL_RST;
            wpct_ff   <= PCT_RST;
            rspd_ff   <= SPD_RST;
            lspd_ff   <= SPD_RST;
            glvl_ff   <= LVL_RST;
            status_ff <= 4'h0;
            mask_ff   <= 4'h0;
            irq_ff    <= 1'b0;
        end
        else
        begin
            linSel_ff <= nxt_linSel;
            arst_ff   <= nxt_arst;
            alvl_ff   <= nxt_alvl;
            wpct_ff   <= nxt_wpct;
            rspd_ff   <= nxt_rspd;
            lspd_ff   <= nxt_lspd;
            glvl_ff   <= nxt_glvl;
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            irq_ff    <= |(nxt_status & nxt_mask);
        end
    end

    // ------------------------------------------------------------
    // enable guard
    // ------------------------------------------------------------
    always_comb
    begin
        overAlvl    = devMag > {2'h0, alvl_ff};
        overGen     = devMag > {2'h0, glvl_ff};
        overWarn    = devMag > {2'h0, warnLvl};
        enaRise     = enableCmd && !enaPrev_ff;
        nxt_state   = state_ff;
        nxt_lim     = lim_ff;
        nxt_refSeen = refSeen_ff;
        nxt_warn    = warn_ff;
        evt         = 4'h0;
        unique case (state_ff)
            SOG_OFF:
            begin
                if (enaRise && alarm_ff == 4'h0)
                begin
                    if (overAlvl)
                        evt[ST_ENA] = 1'b1;
                    else
                    begin
                        nxt_state   = SOG_ON;
                        nxt_lim     = devMag != 32'h00000000;
                        nxt_refSeen = 1'b0;
                        nxt_warn    = overWarn;
                        evt[ST_WARN] = overWarn;
                    end
                end
            end
            SOG_ON:
            begin
                if (lim_ff && posRefValid)
                    nxt_refSeen = 1'b1;
                if (lim_ff && (refSeen_ff || posRefValid) && overGen)
                    evt[ST_SPD] = 1'b1;
                else if (overGen)
                    evt[ST_GEN] = 1'b1;
                if (devMag == 32'h00000000)
                    nxt_lim = 1'b0;
                if (!enableCmd || evt != 4'h0 || alarm_ff != 4'h0)
                begin
                    nxt_state   = SOG_OFF;
                    nxt_lim     = 1'b0;
                    nxt_refSeen = 1'b0;
                    nxt_warn    = 1'b0;
                end
            end
        endcase
        // latched until reset request with condition gone
        nxt_alarm = alarm_ff;
        if (arst_ff)
        begin
            if (!overAlvl)
                nxt_alarm[ST_ENA] = 1'b0;
            if (!overGen)
                nxt_alarm[ST_SPD] = 1'b0;
            if (!overGen)
                nxt_alarm[ST_GEN] = 1'b0;
        end
        nxt_alarm[ST_ENA] = nxt_alarm[ST_ENA] | evt[ST_ENA];
        nxt_alarm[ST_SPD] = nxt_alarm[ST_SPD] | evt[ST_SPD];
        nxt_alarm[ST_GEN] = nxt_alarm[ST_GEN] | evt[ST_GEN];
        nxt_alarm[ST_WARN] = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_ff   <= SOG_OFF;
            enaPrev_ff <= 1'b0;
            lim_ff     <= 1'b0;
            refSeen_ff <= 1'b0;
            warn_ff    <= 1'b0;
            alarm_ff   <= 4'h0;
            spd_ff     <= SPD_RST;
        end
        else
        begin
            state_ff   <= nxt_state;
            enaPrev_ff <= enableCmd;
            lim_ff     <= nxt_lim;
            refSeen_ff <= nxt_refSeen;
            warn_ff    <= nxt_warn;
            alarm_ff   <= nxt_alarm;
            spd_ff     <= nxt_linSel ? nxt_lspd : nxt_rspd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready     = !awHave_ff;
    assign s_axi_wready      = !wHave_ff;
    assign s_axi_bvalid      = bValid_ff;
    assign s_axi_bresp       = bResp_ff;
    assign s_axi_arready     = !rValid_ff;
    assign s_axi_rvalid      = rValid_ff;
    assign s_axi_rdata       = rData_ff;
    assign s_axi_rresp       = rResp_ff;
    assign servoOn           = state_ff == SOG_ON;
    assign speedLimitActive  = lim_ff;
    assign speedLimit        = spd_ff;
    assign enableTimeWarning = warn_ff;
    assign alarms            = alarm_ff;
    assign irq               = irq_ff;

endmodule

// ### rtl/sog_pkg.sv
package sog_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int DEV_W  = 32;
    localparam int LVL_W  = 30;
    localparam int PCT_W  = 7;
    localparam int SPD_W  = 14;
    localparam int ST_W   = 4;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_ALVL   = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_WPCT   = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_RSPD   = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_LSPD   = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_GLVL   = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_STATE  = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_DEV    = 6'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_ARST = 0;
    localparam int CTRL_LIN  = 1;
    localparam int ST_ENA    = 0;
    localparam int ST_WARN   = 1;
    localparam int ST_SPD    = 2;
    localparam int ST_GEN    = 3;
    localparam int SS_ON     = 0;
    localparam int SS_LIM    = 1;
    localparam int SS_WARN   = 2;
    localparam int SS_ALM    = 4;

    // ------------------------------------------------------------
    // reset values and ranges
    // ------------------------------------------------------------
    localparam logic [LVL_W-1:0] LVL_RST = 30'h0500000;
    localparam logic [LVL_W-1:0] LVL_MIN = 30'h0000001;
    localparam logic [LVL_W-1:0] LVL_MAX = 30'h3fffffff;
    localparam logic [PCT_W-1:0] PCT_RST = 7'h64;
    localparam logic [PCT_W-1:0] PCT_MIN = 7'h0a;
    localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;
    localparam logic [PCT_W-1:0] PCT_DIV = 7'h64;
    localparam logic [SPD_W-1:0] SPD_RST = 14'h2710;
    localparam logic [SPD_W-1:0] SPD_MAX = 14'h2710;
    localparam logic [1:0]       RESP_OK = 2'h0;
    localparam logic [1:0]       RESP_ERR = 2'h2;

    typedef enum {SOG_OFF, SOG_ON} sog_state_t;

    function automatic logic [DEV_W-1:0] devAbs(input logic [DEV_W-1:0] d);
        devAbs = d[DEV_W-1] ? (~d + 32'h00000001) : d;
    endfunction

endpackage

// ### rtl/sog_dev_counter.sv
`timescale 1ns/1ps
module sog_dev_counter
    import sog_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [DEV_W-1:0] posRef,
    input  wire logic [DEV_W-1:0] actualPos,
    output logic      [DEV_W-1:0] devVal_ff,
    output logic      [DEV_W-1:0] devMag_ff
);

    logic [DEV_W-1:0] nxt_devVal;
    logic [DEV_W-1:0] nxt_devMag;

    // ------------------------------------------------------------
    // deviation counter
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_devVal = posRef - actualPos;
        nxt_devMag = devAbs(nxt_devVal);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            devVal_ff <= 32'h00000000;
            devMag_ff <= 32'h00000000;
        end
        else
        begin
            devVal_ff <= nxt_devVal;
            devMag_ff <= nxt_devMag;
        end
    end

endmodule

// ### rtl/sog_warn_level.sv
`timescale 1ns/1ps
module sog_warn_level
    import sog_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [LVL_W-1:0] level,
    input  wire logic [PCT_W-1:0] pct,
    output logic      [LVL_W-1:0] warnLvl_ff
);

    logic [LVL_W+PCT_W-1:0] prod;
    logic [LVL_W+PCT_W-1:0] quot;
    logic [LVL_W-1:0]       nxt_warnLvl;

    // ------------------------------------------------------------
    // level times percentage over one hundred
    // ------------------------------------------------------------
    always_comb
    begin
        prod        = {{PCT_W{1'b0}}, level} * {{LVL_W{1'b0}}, pct};
        quot        = prod / {{LVL_W{1'b0}}, PCT_DIV};
        nxt_warnLvl = quot[LVL_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            warnLvl_ff <= LVL_RST;
        else
            warnLvl_ff <= nxt_warnLvl;
    end

endmodule

// ### verification/sog_host_model.sv
`timescale 1ns/1ps
module sog_host_model
    import sog_pkg::*;
(
    input  wire logic             clk,
    output logic                  enableCmd,
    output logic      [DEV_W-1:0] posRef,
    output logic                  posRefValid,
    output logic      [DEV_W-1:0] actualPos
);
    initial
    begin
        enableCmd   = 1'h0;
        posRef      = 32'h0;
        posRefValid = 1'h0;
        actualPos   = 32'h0;
    end
    // reference and position held until the next call
    task automatic place(input logic [DEV_W-1:0] r, a);
        @(posedge clk);
        posRef    <= r;
        actualPos <= a;
    endtask
    // new reference held, with posRefValid pulsed for one cycle
    task automatic refStep(input logic [DEV_W-1:0] r);
        @(posedge clk);
        posRef      <= r;
        posRefValid <= 1'h1;
        @(posedge clk);
        posRefValid <= 1'h0;
    endtask
    task automatic setEnable(input logic b);
        @(posedge clk);
        enableCmd <= b;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ### verification/sog_guard_assertions.sv
`timescale 1ns/1ps
module sog_guard_assertions
    import sog_pkg::*;
(
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic             s_axi_wvalid,
    input wire logic             enableCmd,
    input wire logic             servoOn,
    input wire logic             speedLimitActive,
    input wire logic [SPD_W-1:0] speedLimit,
    input wire logic             enableTimeWarning,
    input wire logic [ST_W-1:0]  alarms
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_onCause;
        $rose(servoOn) |-> $past(enableCmd) && !$past(enableCmd, 2)
            && $past(alarms) == 4'h0;
    endproperty
    a_onCause: assert property (p_onCause)
        else $error("servo on without enable");
    property p_enaAlarm;
        $rose(alarms[0]) |-> $past(enableCmd) && !$past(enableCmd, 2);
    endproperty
    a_enaAlarm: assert property (p_enaAlarm)
        else $error("enable alarm without enable");
    property p_warnCause;
        $rose(enableTimeWarning) |-> $past(enableCmd)
            && !$past(enableCmd, 2);
    endproperty
    a_warnCause: assert property (p_warnCause)
        else $error("warning without enable");
    property p_limitOn;
        speedLimitActive |-> servoOn;
    endproperty
    a_limitOn: assert property (p_limitOn)
        else $error("limiting while off");
    property p_spdAlarm;
        $rose(alarms[2]) |-> $past(speedLimitActive);
    endproperty
    a_spdAlarm: assert property (p_spdAlarm)
        else $error("speed alarm without limiting");
    property p_spdMax;
        speedLimit <= SPD_MAX;
    endproperty
    a_spdMax: assert property (p_spdMax)
        else $error("speed limit above range");
    property p_stopped;
        alarms != 4'h0 |-> !servoOn;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("axis on with alarm");
    property p_hold;
        $fell(|alarms) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
            || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4);
    endproperty
    a_hold: assert property (p_hold)
        else $error("alarm dropped without reset");
endmodule
bind sog_guard sog_guard_assertions u_chk (.clk(clk), .rstn(rstn),
    .s_axi_wvalid(s_axi_wvalid), .enableCmd(enableCmd),
    .servoOn(servoOn), .speedLimitActive(speedLimitActive),
    .speedLimit(speedLimit), .enableTimeWarning(enableTimeWarning),
    .alarms(alarms));

// ### verification/test_servo_on_deviation_guard.sv
`timescale 1ns/1ps
module test_servo_on_deviation_guard
    import sog_pkg::*;
;
    logic clk, rstn, awV, awR, wV, wR, bV, bR, arV, arR, rV, rR, ena, prv;
    logic on, lim, warn, irq;
    logic [ADDR_W-1:0] awA, arA;
    logic [31:0] wD, rD, pr, ap, d;
    logic [1:0] bRsp, rRsp, rsp;
    logic [SPD_W-1:0] spd;
    logic [ST_W-1:0] alm;
    int mismatches, samples_checked;
    typedef struct {logic [5:0] a; logic wr; logic [31:0] wd, ed;
        logic [1:0] er;} sog_row_t;
    sog_row_t rows [14] = '{
        '{OFF_ALVL, 1'h0, 32'h0, 32'h00500000, RESP_OK},
        '{OFF_WPCT, 1'h0, 32'h0, 32'h64, RESP_OK},
        '{OFF_RSPD, 1'h0, 32'h0, 32'h2710, RESP_OK},
        '{OFF_LSPD, 1'h0, 32'h0, 32'h2710, RESP_OK},
        '{OFF_GLVL, 1'h0, 32'h0, 32'h00500000, RESP_OK},
        '{OFF_STATUS, 1'h0, 32'h0, 32'h0, RESP_OK},
        '{OFF_WPCT, 1'h1, 32'h5, 32'h64, RESP_OK},
        '{OFF_WPCT, 1'h1, 32'h32, 32'h32, RESP_OK},
        '{OFF_RSPD, 1'h1, 32'h2711, 32'h2710, RESP_OK},
        '{OFF_LSPD, 1'h1, 32'h1f4, 32'h1f4, RESP_OK},
        '{OFF_ALVL, 1'h1, 32'h0, 32'h00500000, RESP_OK},
        '{OFF_GLVL, 1'h1, 32'h003d0900, 32'h003d0900, RESP_OK},
        '{OFF_STATE, 1'h1, 32'h0, 32'h0, RESP_ERR},
        '{6'h28, 1'h0, 32'h0, 32'h0, RESP_ERR}};
    sog_guard u_sog_guard (.clk(clk), .rstn(rstn), .s_axi_awvalid(awV),
        .s_axi_awready(awR), .s_axi_awaddr(awA), .s_axi_wvalid(wV),
        .s_axi_wready(wR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_bresp(bRsp),
        .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_araddr(arA),
        .s_axi_rvalid(rV), .s_axi_rready(rR), .s_axi_rdata(rD),
        .s_axi_rresp(rRsp), .enableCmd(ena), .posRef(pr),
        .posRefValid(prv), .actualPos(ap), .servoOn(on),
        .speedLimitActive(lim), .speedLimit(spd),
        .enableTimeWarning(warn), .alarms(alm), .irq(irq));
    sog_host_model u_sog_host_model (.clk(clk), .enableCmd(ena),
        .posRef(pr), .posRefValid(prv), .actualPos(ap));
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        awV <= 1'h1; wV <= 1'h1; awA <= a; wD <= v; bR <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awR && awV) awV <= 1'h0;
            if (wR && wV) wV <= 1'h0;
        end while (!bV);
        rsp = bRsp;
    endtask
    task automatic rd(input logic [5:0] a);
        arV <= 1'h1; arA <= a; rR <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arR && arV) arV <= 1'h0;
        end while (!rV);
        d = rD;
        rsp = rRsp;
    endtask
    task automatic give_verdict();
        $display("checked %0d bad %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // whole run is well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial
    begin
        {awV, wV, bR, arV, rR, rstn} = 6'h0;
        {awA, arA, wD} = 44'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        chk({on, lim, warn, irq, alm}, 8'h0);
        chk(spd, 14'h2710);
        $display("reset done");
        foreach (rows[i])
        begin
            if (rows[i].wr) wr(rows[i].a, rows[i].wd);
            if (rows[i].wr) chk(rsp, rows[i].er);
            rd(rows[i].a);
            if (rows[i].wr || rows[i].er === RESP_OK)
                chk(d, rows[i].ed);
            if (!rows[i].wr) chk(rsp, rows[i].er);
        end
        $display("table done");
        wr(OFF_MASK, 32'hf);
        u_sog_host_model.place(32'h005b8d80, 32'h0);
        u_sog_host_model.setEnable(1'h1);
        chk({on, alm, irq}, 6'h03);
        u_sog_host_model.setEnable(1'h0);
        u_sog_host_model.setEnable(1'h1);
        chk(on, 1'h0);
        u_sog_host_model.place(32'h0, 32'h0);
        u_sog_host_model.setEnable(1'h0);
        wr(OFF_CTRL, 32'h3);
        wr(OFF_STATUS, 32'hf);
        repeat (2) @(posedge clk);
        chk({alm, irq}, 5'h0);
        $display("enable alarm done");
        u_sog_host_model.place(32'h002dc6c0, 32'h5);
        u_sog_host_model.setEnable(1'h1);
        chk({on, lim, warn, spd}, {3'h7, 14'h1f4});
        rd(OFF_DEV);
        chk(d, 32'h002dc6bb);
        rd(OFF_STATE);
        chk(d, 32'h7);
        u_sog_host_model.refStep(32'h0044aa25);
        repeat (3) @(posedge clk);
        chk({on, alm, irq}, 6'h09);
        rd(OFF_STATUS);
        chk(d, 32'h6);
        $display("speed alarm done");
        u_sog_host_model.place(32'h0, 32'h0);
        u_sog_host_model.setEnable(1'h0);
        wr(OFF_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        u_sog_host_model.setEnable(1'h1);
        chk({on, lim, alm}, 6'h20);
        u_sog_host_model.place(32'h0044aa20, 32'h0);
        repeat (4) @(posedge clk);
        chk({on, alm}, 5'h08);
        $display("general alarm done");
        give_verdict();
    end
endmodule
